// ===== thermal_pkg.sv
// Purpose: Constants and types of the thermal overload stage.
// Assumes: 250 MHz core clock, APB register access.
// Notes:   Rise is held as a fraction with 2**24 equal to the trip limit.
//
// Behaviour
// - Phase rms is the windowed mean square of raw samples, harmonics kept.
// - Highest of the three phase rms values feeds model and is reported.
// - Model state is the rise fraction, 1.2 meaning 120 percent rise.
// - Trip when rise reaches 100 percent of service and ambient limit.
// - Start asserts when rise reaches the settable alarm percentage.
// - Trip and start release below their thresholds times 0.95 in rise.
// - Tau sets heating rate; trip time uses a natural logarithm estimate.
// - Tau times cooling coefficient applies below 0.3 times rated current.
// - Cooling coefficient resets to 1.0.
// - Ambient factor follows ambient temperature and 40 and 70 C loads.
// - Ambient factor is one for 40 C load 1.0, no sensor, or 40 C.
// - 40 C load resets to 100 percent; manual ambient resets to 40 C.
// - Ambient source is none or one of sixteen external inputs.
// - Rise starts at 70 percent after reset, then follows current.
// - Status shows blocked, started or tripped; start and trip counted.
// - Time to trip is reported in hours, minutes, seconds with rise.
// - Rise percentage reads 100 at the trip limit.
// - Common test force flag clears itself after five minutes.
package thermal_pkg;
  localparam int CLK_HZ          = 250_000_000;
  localparam int FORCE_TIMEOUT_S = 300;
  localparam longint FORCE_CYCLES_DEF = longint'(FORCE_TIMEOUT_S) * CLK_HZ;
  localparam int SEC_PER_MIN     = 60;

  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_SERVICE = 8'h04;
  localparam logic [7:0] ADDR_RATED   = 8'h08;
  localparam logic [7:0] ADDR_TAU     = 8'h0C;
  localparam logic [7:0] ADDR_AMB     = 8'h10;
  localparam logic [7:0] ADDR_TAMB    = 8'h14;
  localparam logic [7:0] ADDR_STATUS  = 8'h18;
  localparam logic [7:0] ADDR_MEAS    = 8'h1C;
  localparam logic [7:0] ADDR_COUNT   = 8'h20;
  localparam logic [7:0] ADDR_TTT     = 8'h24;
  localparam logic [7:0] ADDR_RISE    = 8'h28;

  localparam int CTRL_EN     = 0;
  localparam int CTRL_FORCE  = 1;
  localparam int CTRL_FSTART = 2;
  localparam int CTRL_FTRIP  = 3;
  localparam int CTRL_CLR    = 4;
  localparam int CTRL_SEL    = 8;

  localparam logic [31:0] CTRL_RST    = 32'h0000_0001;
  localparam logic [31:0] SERVICE_RST = 32'h0050_0100;
  localparam logic [31:0] RATED_RST   = 32'h0000_0400;
  localparam logic [31:0] TAU_RST     = 32'h0100_001E;
  localparam logic [31:0] AMB_RST     = 32'h0100_0100;
  localparam logic [15:0] TAMB_RST    = 16'h0028;

  localparam logic [15:0] Q8_ONE      = 16'h0100;
  localparam logic [31:0] THETA_ONE   = 32'h0100_0000;
  localparam logic [31:0] THETA_INIT  = 32'h00B3_3333;
  localparam logic [31:0] THETA_PCT   = 32'h0002_8F5C;
  localparam logic [16:0] REL_Q16     = 17'h0F333;
  localparam logic [16:0] AMB_REF_C   = 17'h00028;
  localparam logic [16:0] AMB_RECIP   = 17'h00889;
  localparam logic [15:0] COOL_Q8     = 16'h004D;
  localparam logic [15:0] LN2_Q8      = 16'h00B1;
  localparam logic [5:0]  MIN_SEC     = 6'h3C;
  localparam logic [47:0] HOUR_SEC    = 48'h0000_0000_0E10;
  localparam logic [7:0]  PCT_FULL    = 8'h64;
  localparam logic [5:0]  DIV_STEPS   = 6'h30;
  localparam logic [5:0]  FRAC_POINT  = 6'h10;

  typedef struct packed {
    logic signed [15:0] l3;
    logic signed [15:0] l2;
    logic signed [15:0] l1;
  } phase_samples_t;

  typedef enum logic [6:0] {
    ST_IDLE  = 7'b0000001,
    ST_ROOT  = 7'b0000010,
    ST_TGT   = 7'b0000100,
    ST_STEP  = 7'b0001000,
    ST_RATIO = 7'b0010000,
    ST_HOUR  = 7'b0100000,
    ST_MIN   = 7'b1000000
  } seq_state_t;
endpackage

// ===== thermal_overload_stage.sv
// Purpose: Thermal image overload stage with start, trip and trip estimate.
// Assumes: Phase samples arrive on core_clk_i with a one-cycle valid.
// Notes:   One update of the model runs per window of 2**WIN_LOG2 samples.
//
// Added by the designer: the register addresses and the APB interface to the registers.
module thermal_overload_stage
  import thermal_pkg::*;
#(
  parameter int     SAMPLE_HZ    = 1600,
  parameter int     WIN_LOG2     = 5,
  parameter int     N_EXT        = 16,
  parameter longint FORCE_CYCLES = FORCE_CYCLES_DEF
) (
  input  wire logic                       core_clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       psel_i,
  input  wire logic                       penable_i,
  input  wire logic                       pwrite_i,
  input  wire logic [7:0]                 paddr_i,
  input  wire logic [31:0]                pwdata_i,
  output logic      [31:0]                prdata_o,
  output logic                            pready_o,
  output logic                            pslverr_o,
  input  wire logic                       sample_valid_i,
  input  wire phase_samples_t             sample_i,
  input  wire logic [N_EXT-1:0][15:0]     external_analogue_input_i,
  output logic                            start_o,
  output logic                            trip_o,
  output logic                            force_o
);
  localparam int ACC_W = 32 + WIN_LOG2;
  localparam logic [47:0] UPD_PER_MIN =
    48'((SAMPLE_HZ * SEC_PER_MIN) >> WIN_LOG2);

  ////////////////////////////////////////////////////////////////////////////
  // Register bus.
  logic [31:0] ctrl, service, rated, tau_reg, amb;
  logic [15:0] tamb;
  logic        force_flag;
  logic [39:0] force_cnt;
  logic [15:0] start_event_count, trip_event_count;
  logic [15:0] highest_phase_current, ambient_corrected_limit;
  logic [15:0] ttt_h;
  logic [5:0]  ttt_m, ttt_s;
  logic [31:0] theta;
  logic        start_m, trip_m;

  wire access = psel_i & penable_i & pready_o;
  wire wr     = access & pwrite_i;
  wire hit    = (paddr_i <= ADDR_RISE) && (paddr_i[1:0] == 2'b00);
  wire wr_ctrl = wr && (paddr_i == ADDR_CTRL);
  wire clr_cnt = wr_ctrl & pwdata_i[CTRL_CLR];

  wire        en        = ctrl[CTRL_EN];
  wire [4:0]  amb_sel   = ctrl[CTRL_SEL +: 5];
  wire [15:0] svc_k     = service[15:0];
  wire [7:0]  alarm_pct = service[23:16];
  wire [15:0] rated_current_basis = rated[15:0];
  wire [15:0] tau_min   = tau_reg[15:0];
  wire [15:0] ctau      = tau_reg[31:16];
  wire [15:0] load_limit_at_40c = amb[15:0];
  wire [15:0] load_limit_at_70c = amb[31:16];
  wire [15:0] rise_pct;

  wire [31:0] rd_data =
    (paddr_i == ADDR_CTRL)    ? {ctrl[31:2], force_flag, ctrl[0]} :
    (paddr_i == ADDR_SERVICE) ? service :
    (paddr_i == ADDR_RATED)   ? rated :
    (paddr_i == ADDR_TAU)     ? tau_reg :
    (paddr_i == ADDR_AMB)     ? amb :
    (paddr_i == ADDR_TAMB)    ? {16'h0000, tamb} :
    (paddr_i == ADDR_STATUS)  ? {rise_pct, 12'h000, force_flag,
                                 trip_o, start_o, ~en} :
    (paddr_i == ADDR_MEAS)    ? {ambient_corrected_limit,
                                 highest_phase_current} :
    (paddr_i == ADDR_COUNT)   ? {trip_event_count, start_event_count} :
    (paddr_i == ADDR_TTT)     ? {ttt_h, 2'b00, ttt_m, 2'b00, ttt_s} :
    (paddr_i == ADDR_RISE)    ? theta : 32'h0000_0000;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
    end else begin
      pready_o  <= psel_i & penable_i & ~pready_o;
      pslverr_o <= psel_i & penable_i & ~pready_o & ~hit;
      prdata_o  <= rd_data;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl    <= CTRL_RST;
      service <= SERVICE_RST;
      rated   <= RATED_RST;
      tau_reg <= TAU_RST;
      amb     <= AMB_RST;
      tamb    <= TAMB_RST;
    end else if (wr) begin
      if (paddr_i == ADDR_CTRL) begin
        ctrl <= {pwdata_i[31:5], 1'b0, pwdata_i[3:0]};
      end else if (paddr_i == ADDR_SERVICE) begin
        service <= pwdata_i;
      end else if (paddr_i == ADDR_RATED) begin
        rated <= pwdata_i;
      end else if (paddr_i == ADDR_TAU) begin
        tau_reg <= pwdata_i;
      end else if (paddr_i == ADDR_AMB) begin
        amb <= pwdata_i;
      end else if (paddr_i == ADDR_TAMB) begin
        tamb <= pwdata_i[15:0];
      end
    end
  end

  // The flag times out unless software sets it again in the same cycle.
  wire force_done = force_flag && (force_cnt == 40'(FORCE_CYCLES - 1));
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      force_flag <= 1'b0;
      force_cnt  <= 40'h00_0000_0000;
    end else begin
      if (wr_ctrl) begin
        force_flag <= pwdata_i[CTRL_FORCE];
      end else if (force_done) begin
        force_flag <= 1'b0;
      end
      force_cnt <= (force_flag && !wr_ctrl && !force_done) ?
                   force_cnt + 40'h00_0000_0001 : 40'h00_0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Windowed mean square of each phase, wideband samples.
  logic [WIN_LOG2-1:0] samp_cnt;
  logic [ACC_W-1:0]    acc [3];
  logic                window_done;
  logic [31:0]         max_ms;
  wire signed [15:0] ph [3] = '{sample_i.l1, sample_i.l2, sample_i.l3};
  wire [31:0] ms0 = 32'(acc[0] >> WIN_LOG2);
  wire [31:0] ms1 = 32'(acc[1] >> WIN_LOG2);
  wire [31:0] ms2 = 32'(acc[2] >> WIN_LOG2);
  wire [31:0] ms01 = (ms0 > ms1) ? ms0 : ms1;
  wire [31:0] ms_hi = (ms01 > ms2) ? ms01 : ms2;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      samp_cnt    <= '0;
      window_done <= 1'b0;
      for (int i = 0; i < 3; i++) begin
        acc[i] <= '0;
      end
    end else begin
      window_done <= sample_valid_i && (samp_cnt == '1);
      if (sample_valid_i) begin
        samp_cnt <= samp_cnt + 1'b1;
        for (int i = 0; i < 3; i++) begin
          acc[i] <= ((samp_cnt == '0) ? '0 : acc[i]) +
                    ACC_W'(unsigned'(32'(ph[i]) * 32'(ph[i])));
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ambient factor and allowed current.
  logic [15:0] kth;
  logic [47:0] imax_sq;
  wire no_sensor = (amb_sel == 5'h00) || (amb_sel > 5'(N_EXT));
  wire [4:0] ext_idx = amb_sel - 5'h01;
  wire signed [16:0] amb_t = no_sensor ? 17'(signed'(tamb)) :
    17'(signed'(external_analogue_input_i[ext_idx[$clog2(N_EXT)-1:0]]));
  wire signed [16:0] dl  = signed'({1'b0, load_limit_at_70c}) -
                           signed'({1'b0, load_limit_at_40c});
  wire signed [16:0] dtm = amb_t - signed'(AMB_REF_C);
  wire signed [47:0] p2  = 48'(dl) * 48'(dtm) * 48'(signed'(AMB_RECIP));
  wire signed [31:0] kth_s = 32'(signed'({1'b0, load_limit_at_40c})) +
                             p2[47:16];
  wire kth_one = (load_limit_at_40c == Q8_ONE) || no_sensor ||
                 (dtm == 17'h00000);
  wire [15:0] kth_c = kth_one ? Q8_ONE : kth_s[31] ? 16'h0000 :
                      (|kth_s[30:16]) ? 16'hFFFF : kth_s[15:0];
  wire [31:0] lim_p = svc_k * kth;
  wire [15:0] lim_c = (|lim_p[31:24]) ? 16'hFFFF : lim_p[23:8];
  wire [31:0] imax  = rated_current_basis * ambient_corrected_limit;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      kth                     <= Q8_ONE;
      ambient_corrected_limit <= Q8_ONE;
      imax_sq                 <= 48'h0000_0000_0001;
    end else begin
      kth                     <= kth_c;
      ambient_corrected_limit <= lim_c;
      imax_sq                 <= 48'(imax[31:8]) * 48'(imax[31:8]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Update sequencer with a shared serial divider.
  seq_state_t  state;
  logic        pend, dv_run;
  logic [47:0] dv_num, dv_den, dv_rem;
  logic [5:0]  dv_cnt;
  logic [15:0] root, root_bit;
  logic [31:0] target;
  logic [47:0] secs;

  wire [48:0] dv_sh  = {dv_rem, dv_num[47]};
  wire        dv_ge  = dv_sh >= {1'b0, dv_den};
  wire [48:0] dv_sub = dv_sh - {1'b0, dv_den};
  wire [47:0] quo    = dv_num;
  wire        dv_ok  = pend && !dv_run;

  wire [15:0] trial = root | root_bit;
  wire [31:0] low_p = 32'(rated_current_basis) * 32'(COOL_Q8);
  wire [15:0] low_i = low_p[23:8];
  wire        cooling = max_ms < (32'(low_i) * 32'(low_i));
  wire [15:0] ctau_eff = cooling ? ctau : Q8_ONE;
  wire [47:0] step_den = UPD_PER_MIN * 48'(tau_min) *
                         48'(ctau_eff);
  wire        going_dn = theta > target;
  wire [31:0] diff = going_dn ? theta - target : target - theta;
  wire [31:0] tgt_q = (|quo[47:24]) ? 32'hFFFF_FFFF : {quo[23:0], 8'h00};
  wire [32:0] up_sum = {1'b0, theta} + {1'b0, quo[31:0]};
  wire [31:0] theta_up = up_sum[32] ? 32'hFFFF_FFFF : up_sum[31:0];
  wire [31:0] theta_dn = (quo[31:0] > diff) ? target : theta - quo[31:0];
  wire        can_trip = (target > THETA_ONE) && (theta < THETA_ONE);

  function automatic logic [5:0] msb_pos(input logic [47:0] v);
    logic [5:0] p;
    p = 6'h00;
    for (int i = 0; i < 48; i++) begin
      if (v[i]) begin
        p = 6'(i);
      end
    end
    return p;
  endfunction

  // Logarithm approximated as integer part of log2 plus linear mantissa.
  wire [5:0]  lp      = msb_pos(quo);
  wire [47:0] norm    = quo << (6'h2F - lp);
  wire [13:0] log2_q8 = {(lp - FRAC_POINT), norm[46:39]};
  wire [21:0] ln_q8   = 22'((32'(log2_q8) * 32'(LN2_Q8)) >> 8);
  wire [47:0] secs_c  = 48'((48'(tau_min) * 48'(SEC_PER_MIN) *
                             48'(ln_q8)) >> 8);

  wire [47:0] next_num =
    (state == ST_TGT)   ? {max_ms, 16'h0000} :
    (state == ST_STEP)  ? {8'h00, diff, 8'h00} :
    (state == ST_RATIO) ? {target - theta, 16'h0000} :
    (state == ST_HOUR)  ? secs : dv_rem;
  wire [47:0] next_den =
    (state == ST_TGT)   ? imax_sq :
    (state == ST_STEP)  ? step_den :
    (state == ST_RATIO) ? {16'h0000, target - THETA_ONE} :
    (state == ST_HOUR)  ? HOUR_SEC : 48'(MIN_SEC);

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      dv_run <= 1'b0;
      dv_cnt <= 6'h00;
      dv_num <= 48'h0000_0000_0000;
      dv_den <= 48'h0000_0000_0001;
      dv_rem <= 48'h0000_0000_0000;
    end else if (pend && !dv_run && state != ST_IDLE) begin
      dv_run <= 1'b0;
    end else if (!pend && (state & (ST_TGT | ST_STEP | ST_RATIO |
                                    ST_HOUR | ST_MIN)) != '0) begin
      dv_run <= 1'b1;
      dv_cnt <= DIV_STEPS;
      dv_num <= next_num;
      dv_den <= next_den;
      dv_rem <= 48'h0000_0000_0000;
    end else if (dv_run) begin
      dv_rem <= dv_ge ? dv_sub[47:0] : dv_sh[47:0];
      dv_num <= {dv_num[46:0], dv_ge};
      dv_cnt <= dv_cnt - 6'h01;
      dv_run <= (dv_cnt != 6'h01);
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state    <= ST_IDLE;
      pend     <= 1'b0;
      max_ms   <= 32'h0000_0000;
      root     <= 16'h0000;
      root_bit <= 16'h0000;
      target   <= THETA_INIT;
      theta    <= THETA_INIT;
      secs     <= 48'h0000_0000_0000;
      ttt_h    <= 16'hFFFF;
      ttt_m    <= 6'h3F;
      ttt_s    <= 6'h3F;
      highest_phase_current <= 16'h0000;
    end else begin
      case (state)
        ST_IDLE: begin
          if (window_done) begin
            max_ms   <= ms_hi;
            root     <= 16'h0000;
            root_bit <= 16'h8000;
            state    <= ST_ROOT;
          end
        end
        ST_ROOT: begin
          if (32'(trial) * 32'(trial) <= max_ms) begin
            root <= trial;
          end
          root_bit <= root_bit >> 1;
          if (root_bit[0]) begin
            highest_phase_current <= (32'(trial) * 32'(trial) <= max_ms) ?
                                     trial : root;
            state <= ST_TGT;
          end
        end
        ST_TGT: begin
          pend <= !dv_ok;
          if (dv_ok) begin
            target <= tgt_q;
            state  <= ST_STEP;
          end
        end
        ST_STEP: begin
          pend <= !dv_ok;
          if (dv_ok) begin
            theta <= going_dn ? theta_dn : theta_up;
            state <= ST_RATIO;
          end
        end
        ST_RATIO: begin
          if (!can_trip) begin
            ttt_h <= (theta >= THETA_ONE) ? 16'h0000 : 16'hFFFF;
            ttt_m <= (theta >= THETA_ONE) ? 6'h00 : 6'h3F;
            ttt_s <= (theta >= THETA_ONE) ? 6'h00 : 6'h3F;
            state <= ST_IDLE;
          end else begin
            pend <= !dv_ok;
            if (dv_ok) begin
              secs  <= secs_c;
              state <= ST_HOUR;
            end
          end
        end
        ST_HOUR: begin
          pend <= !dv_ok;
          if (dv_ok) begin
            ttt_h <= (|quo[47:16]) ? 16'hFFFF : quo[15:0];
            state <= ST_MIN;
          end
        end
        ST_MIN: begin
          pend <= !dv_ok;
          if (dv_ok) begin
            ttt_m <= quo[5:0];
            ttt_s <= dv_rem[5:0];
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
          pend  <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Start and trip with release hysteresis, counters and outputs.
  wire [31:0] alarm_th  = 32'(alarm_pct) * THETA_PCT;
  wire [31:0] alarm_rel = 32'((48'(alarm_th) * 48'(REL_Q16)) >> 16);
  wire [31:0] trip_rel  = 32'((48'(THETA_ONE) * 48'(REL_Q16)) >> 16);
  wire [47:0] pct_p     = 48'(theta) * 48'(PCT_FULL);
  assign rise_pct = (|pct_p[47:40]) ? 16'hFFFF : pct_p[39:24];

  wire next_trip_m  = en && (trip_m ? (theta >= trip_rel) :
                             (theta >= THETA_ONE));
  wire next_start_m = en && (start_m ? (theta >= alarm_rel) :
                             (theta >= alarm_th));
  wire next_start = (force_flag && ctrl[CTRL_FSTART]) || next_start_m;
  wire next_trip  = (force_flag && ctrl[CTRL_FTRIP]) || next_trip_m;
  wire start_rise = next_start & ~start_o;
  wire trip_rise  = next_trip & ~trip_o;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      start_m <= 1'b0;
      trip_m  <= 1'b0;
      start_o <= 1'b0;
      trip_o  <= 1'b0;
      force_o <= 1'b0;
    end else begin
      start_m <= next_start_m;
      trip_m  <= next_trip_m;
      start_o <= next_start;
      trip_o  <= next_trip;
      force_o <= force_flag;
    end
  end

  // A count event in the clearing cycle survives as a count of one.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      start_event_count <= 16'h0000;
      trip_event_count  <= 16'h0000;
    end else begin
      start_event_count <= (clr_cnt ? 16'h0000 : start_event_count) +
                           16'(start_rise);
      trip_event_count  <= (clr_cnt ? 16'h0000 : trip_event_count) +
                           16'(trip_rise);
    end
  end
endmodule

// ===== thermal_overload_checker.sv
// Purpose: Checks bus timing and flag outputs of the thermal stage.
// Assumes: One clock domain, asynchronous active high reset.
// Notes:   Force hold time is measured by a helper counter.
module thermal_overload_checker
  import thermal_pkg::*;
#(
  parameter longint FORCE_CYCLES = FORCE_CYCLES_DEF
) (
  input wire logic       core_clk_i,
  input wire logic       rst_i,
  input wire logic       psel_i,
  input wire logic       penable_i,
  input wire logic [7:0] paddr_i,
  input wire logic       pready_o,
  input wire logic       pslverr_o,
  input wire logic       start_o,
  input wire logic       trip_o,
  input wire logic       force_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  logic [63:0] force_len;
  wire bad_addr = (paddr_i > ADDR_RISE) || (paddr_i[1:0] != 2'h0);
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) force_len <= '0;
    else force_len <= force_o ? force_len + 64'h1 : '0;
  end
  sequence acc_start;
    psel_i && $rose(penable_i);
  endsequence
  sequence acc_bad;
    psel_i && $rose(penable_i) && bad_addr;
  endsequence
  sequence acc_good;
    psel_i && $rose(penable_i) && !bad_addr;
  endsequence
  chk_ready_wait: assert property (acc_start |=> pready_o)
    else $error("pready late");
  chk_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("pready held");
  chk_ready_cause: assert property (pready_o |-> $past(penable_i))
    else $error("pready without access");
  chk_err_unmapped: assert property (acc_bad |=> pslverr_o)
    else $error("no error on bad address");
  chk_err_mapped: assert property (acc_good |=> pready_o && !pslverr_o)
    else $error("error on mapped address");
  chk_err_ready: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  chk_reset_out: assert property ($fell(rst_i) |-> !start_o &&
    !trip_o && !force_o) else $error("outputs set after reset");
  chk_force_hold: assert property (force_o |->
    force_len <= FORCE_CYCLES + 2)
    else $error("force flag held too long");
endmodule
bind thermal_overload_stage thermal_overload_checker #(
  .FORCE_CYCLES(FORCE_CYCLES)) thermal_overload_checker_inst (.core_clk_i,
  .rst_i, .psel_i, .penable_i, .paddr_i, .pready_o, .pslverr_o, .start_o,
  .trip_o, .force_o);

// ===== tb.sv
// Purpose: Self-checking bench of the thermal overload stage.
// Assumes: Short force timeout parameter, random sample signs.
// Notes:   Expected values come from the reset table and the rules.
module tb import thermal_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam longint FC = 1000;
  logic core_clk_i, rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
  logic sample_valid_i, start_o, trip_o, force_o, e;
  logic [7:0]  paddr_i;
  logic [31:0] pwdata_i, prdata_o, r, w, seed;
  phase_samples_t sample_i;
  logic [15:0][15:0] external_analogue_input_i;
  int errors, checks_done;
  logic [31:0] rst_val [0:5];
  logic [31:0] mask [0:5];
  thermal_overload_stage #(.FORCE_CYCLES(FC)) thermal_overload_stage_inst (
    .core_clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .sample_valid_i,
    .sample_i, .external_analogue_input_i, .start_o, .trip_o, .force_o);
  task automatic end_of_test;
    $display("checks_done %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic cmp(input string s, input logic [31:0] x, logic [31:0] g);
    checks_done++;
    if (g !== x) begin
      errors++;
      $display("ERROR %s expected %h seen %h", s, x, g);
    end
  endtask
  task automatic apb(input logic wr, logic [7:0] a, logic [31:0] d);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge core_clk_i);
    end while (pready_o !== 1'b1);
    r = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge core_clk_i);
  endtask
  function automatic logic [15:0] sg(input logic [15:0] v);
    return $random(seed) & 1 ? v : -v;
  endfunction
  task automatic feed(input int n, input logic [15:0] amp);
    repeat (n) begin
      @(posedge core_clk_i);
      sample_valid_i <= 1'b1;
      sample_i <= {sg(amp / 2), sg(amp), sg(amp / 3)};
    end
    @(posedge core_clk_i);
    sample_valid_i <= 1'b0;
    repeat (400) @(posedge core_clk_i);
  endtask
  initial begin
    core_clk_i = 1'b0;
    forever #2 core_clk_i = ~core_clk_i;
  end
  initial begin
    repeat (20000) @(posedge core_clk_i);
    errors++;
    end_of_test();
  end
  initial begin
    seed = 32'h59A0A9CA;
    rst_val = '{CTRL_RST, SERVICE_RST, RATED_RST, TAU_RST, AMB_RST,
      {16'h0000, TAMB_RST}};
    mask = '{32'h0, 32'h00FFFFFF, 32'h0000FFFF, 32'hFFFFFFFF,
      32'hFFFFFFFF, 32'h0000FFFF};
    {rst_i, psel_i, penable_i, pwrite_i, sample_valid_i} = 5'h10;
    {paddr_i, pwdata_i, sample_i} = '0;
    for (int k = 0; k < 16; k++) external_analogue_input_i[k] = $random(seed);
    repeat (3) @(posedge core_clk_i);
    rst_i <= 1'b0;
    @(posedge core_clk_i);
    for (int i = 0; i < 6; i++) begin
      apb(0, 8'(4 * i), 32'h0);
      cmp("reset value", rst_val[i], r);
    end
    apb(0, ADDR_RISE, 32'h0);
    cmp("initial rise", THETA_INIT, r);
    apb(0, ADDR_TTT, 32'h0);
    cmp("time to trip", 32'hFFFF3F3F, r);
    apb(0, 8'h2C, 32'h0);
    cmp("unmapped", 32'h1, {31'h0, e});
    // Blocked while random settings stand, so no start is counted.
    apb(1, ADDR_CTRL, 32'h0);
    for (int i = 1; i < 6; i++) begin
      w = $random(seed) & mask[i];
      apb(1, 8'(4 * i), w);
      apb(0, 8'(4 * i), 32'h0);
      cmp("readback", w, r);
      apb(1, 8'(4 * i), rst_val[i]);
    end
    apb(1, ADDR_CTRL, CTRL_RST);
    feed(64, 16'h012C);
    apb(0, ADDR_MEAS, 32'h0);
    cmp("highest rms", 32'h012C, {16'h0, r[15:0]});
    cmp("ambient factor", 32'h0100, {16'h0, r[31:16]});
    apb(0, ADDR_RISE, 32'h0);
    cmp("rise cooling", 32'h1, {31'h0, r < THETA_INIT});
    external_analogue_input_i[0] <= 16'h0046;
    apb(1, ADDR_AMB, 32'h014000C0);
    apb(1, ADDR_CTRL, 32'h00000101);
    apb(0, ADDR_MEAS, 32'h0);
    cmp("sensor ambient", 32'h0140, {16'h0, r[31:16]});
    apb(1, ADDR_AMB, AMB_RST);
    apb(1, ADDR_CTRL, 32'h0000000F);
    repeat (3) @(posedge core_clk_i);
    cmp("forced outputs", 32'h7, {start_o, trip_o, force_o});
    apb(0, ADDR_COUNT, 32'h0);
    cmp("counters", 32'h00010001, r);
    repeat (FC + 10) @(posedge core_clk_i);
    cmp("force expired", 32'h0, {start_o, trip_o, force_o});
    apb(1, ADDR_CTRL, 32'h00000011);
    apb(0, ADDR_COUNT, 32'h0);
    cmp("counters cleared", 32'h0, r);
    apb(1, ADDR_CTRL, 32'h0);
    apb(0, ADDR_STATUS, 32'h0);
    cmp("blocked", 32'h1, {31'h0, r[0]});
    end_of_test();
  end
endmodule
